// file: inc/ecc_engine_map.svh
// constant map for the nand parity and ecc engine
`ifndef ECC_ENGINE_MAP_SVH
`define ECC_ENGINE_MAP_SVH

`define PAR_BITS        112
`define CHUNK_BITS      14
`define HAMM_BITS       8'd32
`define MAX_STRENGTH    4'd8
`define HAMM_CHUNKS     4'd3
`define PAR_POLY        112'h8d3b_1c7e_52a9_e64f_0b37_d195_a2c6
`define CALC_LAT        3'd4
`define TERM_INDEX      11'h7fe
`define DATA_FIFO_DEPTH 4
`define LOC_FIFO_DEPTH  16
`define XFER_WIDTH      20
`define LOC_WIDTH       11
`define STAT_NONE       3'b000
`define STAT_SINGLE     3'b001
`define STAT_MULTI      3'b100
`define UNITS_32_BYTE   4'd4
`define UNITS_32_HALF   4'd2
`define UNITS_64_BYTE   4'd8
`define UNITS_64_HALF   4'd4

`endif

// file: inc/ecc_engine_pkg.sv
// types shared by the nand parity and ecc engine
package ecc_engine_pkg;

  typedef logic [111:0] par_t;

  typedef enum logic [1:0] {
    SZ_UNIT,
    SZ_WORD32,
    SZ_WORD64
  } xfer_size_e;

  typedef enum logic [1:0] {
    C_IDLE,
    C_SCAN,
    C_TERM,
    C_DONE
  } corr_state_e;

endpackage

// file: design/nand_parity_ecc_engine.sv
// nand parity generator, syndrome checker and error locator with its fifos
`timescale 1ns/10ps

`include "ecc_engine_map.svh"

module xfer_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b1;
      out_valid  <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
      end
      if (pop) begin
        rd_ptr_reg <= AW'((rd_ptr_reg + 1'b1) % DEPTH);
      end
      // flags kept as flops so both sides see registered handshakes
      unique case ({push, pop})
        2'b10: begin
          count_reg <= count_reg + 1'b1;
          in_ready  <= (count_reg != (AW+1)'(DEPTH - 1));
          out_valid <= 1'b1;
        end
        2'b01: begin
          count_reg <= count_reg - 1'b1;
          in_ready  <= 1'b1;
          out_valid <= (count_reg != (AW+1)'(1));
        end
        default: begin
          count_reg <= count_reg;
        end
      endcase
    end
  end
endmodule

module nand_parity_ecc_engine
  import ecc_engine_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    prty_mode,
  input  wire logic                    hamm_mode,
  input  wire logic [3:0]              ecc_strength,
  input  wire logic [11:0]             blk_size,
  input  wire logic [2:0]              cs_select,
  input  wire logic [3:0]              tag_in,
  input  wire logic                    bus16,
  input  wire logic                    shift_en,
  input  wire logic                    parity_out_sel,
  input  wire logic                    init_req,
  input  wire logic                    corr_start,
  input  wire logic                    acc_valid,
  output logic                         acc_ready,
  input  wire logic                    acc_write,
  input  wire logic [2:0]              acc_cs,
  input  wire ecc_engine_pkg::xfer_size_e acc_size,
  input  wire logic [63:0]             acc_wdata,
  output logic                         rd_valid,
  output logic      [15:0]             rd_data,
  output logic                         exp_valid,
  input  wire logic                    exp_ready,
  output logic                         exp_write,
  output logic      [2:0]              exp_cs,
  output logic      [15:0]             exp_wdata,
  input  wire logic                    exp_rvalid,
  input  wire logic [15:0]             exp_rdata,
  output logic                         idle_status,
  output logic                         corr_required,
  output logic                         erased_page,
  output logic      [2:0]              poly_status,
  output logic      [3:0]              error_count,
  output logic                         uncorrectable,
  output logic                         locator_finished_status,
  output logic      [3:0]              corr_tag,
  input  wire logic                    loc_read,
  output logic                         loc_valid,
  output logic      [10:0]             error_location_port
);
  import ecc_engine_pkg::*;

  // captured settings
  logic        init_reg;
  logic        init_req_q_reg;
  logic        gen_l_reg;
  logic        hamm_l_reg;
  logic [3:0]  strength_l_reg;
  logic [2:0]  cs_l_reg;
  logic        wide_l_reg;
  logic [12:0] target_reg;
  logic [3:0]  nchunk_reg;
  par_t        mask_reg;
  par_t        poly_reg;
  logic [3:0]  strength_next;
  logic [7:0]  len_next;
  logic [7:0]  par_bytes_next;
  par_t        mask_next;

  // self-clearing init: one pulse per request, a held request does not repeat
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      init_reg       <= 1'b0;
      init_req_q_reg <= 1'b0;
    end else begin
      init_reg       <= init_req && !init_req_q_reg;
      init_req_q_reg <= init_req;
    end
  end

  always_comb begin
    strength_next = (ecc_strength > `MAX_STRENGTH) ? `MAX_STRENGTH : ecc_strength;
    len_next = hamm_mode ? `HAMM_BITS : 8'(strength_next * `CHUNK_BITS);
    mask_next = (len_next == 8'd0) ? '0 : ({`PAR_BITS{1'b1}} >> (8'd112 - len_next));
    par_bytes_next = bus16 ? 8'(((len_next + 8'd15) >> 4) << 1) : 8'((len_next + 8'd7) >> 3);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gen_l_reg      <= 1'b1;
      hamm_l_reg     <= 1'b0;
      strength_l_reg <= '0;
      cs_l_reg       <= '0;
      wide_l_reg     <= 1'b0;
      target_reg     <= '0;
      nchunk_reg     <= '0;
      mask_reg       <= '0;
      poly_reg       <= '0;
      corr_tag       <= '0;
    end else if (init_reg) begin
      gen_l_reg      <= prty_mode;
      hamm_l_reg     <= hamm_mode;
      strength_l_reg <= strength_next;
      cs_l_reg       <= cs_select;
      wide_l_reg     <= bus16;
      // syndrome mode also absorbs the stored parity after the block
      target_reg     <= prty_mode ? {1'b0, blk_size} : 13'({1'b0, blk_size} + par_bytes_next);
      nchunk_reg     <= hamm_mode ? `HAMM_CHUNKS : strength_next;
      mask_reg       <= mask_next;
      poly_reg       <= `PAR_POLY & mask_next;
      corr_tag       <= tag_in;
    end
  end

  logic [63:0] split_data_reg;
  logic [3:0]  split_left_reg;
  logic        split_write_reg;
  logic [2:0]  split_cs_reg;
  logic        dq_in_ready;
  logic        dq_out_valid;
  logic        dq_out_ready;
  logic [19:0] dq_out_data;
  logic [3:0]  units_next;

  always_comb begin
    unique case (acc_size)
      SZ_WORD32: units_next = bus16 ? `UNITS_32_HALF : `UNITS_32_BYTE;
      SZ_WORD64: units_next = bus16 ? `UNITS_64_HALF : `UNITS_64_BYTE;
      default:   units_next = 4'd1;
    endcase
    // reads are single units only
    if (!acc_write) begin
      units_next = 4'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_ready       <= 1'b1;
      split_data_reg  <= '0;
      split_left_reg  <= '0;
      split_write_reg <= 1'b0;
      split_cs_reg    <= '0;
    end else if (acc_ready) begin
      if (acc_valid) begin
        acc_ready       <= 1'b0;
        split_data_reg  <= acc_wdata;
        split_left_reg  <= units_next;
        split_write_reg <= acc_write;
        split_cs_reg    <= acc_cs;
      end
    end else if (dq_in_ready) begin
      // one nand unit per push, low unit first
      split_data_reg <= wide_l_reg ? (split_data_reg >> 16) : (split_data_reg >> 8);
      split_left_reg <= split_left_reg - 4'd1;
      acc_ready      <= (split_left_reg == 4'd1);
    end
  end

  xfer_fifo #(
    .WIDTH (`XFER_WIDTH),
    .DEPTH (`DATA_FIFO_DEPTH)
  ) data_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (!acc_ready),
    .in_ready  (dq_in_ready),
    .in_data   ({split_write_reg, split_cs_reg,
                 wide_l_reg ? split_data_reg[15:0] : {8'h00, split_data_reg[7:0]}}),
    .out_valid (dq_out_valid),
    .out_ready (dq_out_ready),
    .out_data  (dq_out_data)
  );

  // parity calculator
  par_t        par_reg;
  par_t        par_next;
  logic [12:0] absorbed_reg;
  logic [2:0]  lat_reg;
  logic        all_ones_reg;
  logic        rd_cs_hit_reg;
  logic        load;
  logic        unit_hit;
  logic        absorb_wr;
  logic        absorb_rd;
  logic        advance;
  logic [15:0] par_unit;
  logic [15:0] absorb_data;

  function automatic par_t par_step(par_t r, logic [15:0] d, logic wide, par_t poly, par_t mask);
    par_t x;
    logic fb;
    x = r;
    for (int i = 0; i < 16; i++) begin
      if (wide || i < 8) begin
        fb = x[0] ^ d[i];
        x  = ((x >> 1) ^ (fb ? poly : '0)) & mask;
      end
    end
    return x;
  endfunction

  assign dq_out_ready = !exp_valid || exp_ready;
  assign load         = dq_out_valid && dq_out_ready;
  assign unit_hit     = load && dq_out_data[19] && (dq_out_data[18:16] == cs_l_reg) && shift_en;
  assign absorb_wr    = unit_hit && gen_l_reg && !parity_out_sel;
  assign advance      = unit_hit && parity_out_sel;
  assign absorb_rd    = exp_rvalid && rd_cs_hit_reg && shift_en && !gen_l_reg;
  assign par_unit     = wide_l_reg ? par_reg[15:0] : {8'h00, par_reg[7:0]};
  assign absorb_data  = absorb_wr ? dq_out_data[15:0] : exp_rdata;

  always_comb begin
    par_next = par_reg;
    if (absorb_wr || absorb_rd) begin
      par_next = par_step(par_reg, absorb_data, wide_l_reg, poly_reg, mask_reg);
    end else if (advance) begin
      par_next = wide_l_reg ? (par_reg >> 16) : (par_reg >> 8);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || init_reg) begin
      par_reg      <= '0;
      absorbed_reg <= '0;
      all_ones_reg <= 1'b1;
    end else begin
      par_reg <= par_next;
      if (absorb_wr || absorb_rd) begin
        absorbed_reg <= absorbed_reg + (wide_l_reg ? 13'd2 : 13'd1);
        if (absorb_data != (wide_l_reg ? 16'hffff : 16'h00ff)) begin
          all_ones_reg <= 1'b0;
        end
      end
    end
  end

  // expansion side output stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      exp_valid     <= 1'b0;
      exp_write     <= 1'b0;
      exp_cs        <= '0;
      exp_wdata     <= '0;
      rd_cs_hit_reg <= 1'b0;
    end else if (load) begin
      exp_valid <= 1'b1;
      exp_write <= dq_out_data[19];
      exp_cs    <= dq_out_data[18:16];
      exp_wdata <= advance ? par_unit : dq_out_data[15:0];
      if (!dq_out_data[19]) begin
        rd_cs_hit_reg <= (dq_out_data[18:16] == cs_l_reg);
      end
    end else if (exp_ready) begin
      exp_valid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= exp_rvalid;
      if (exp_rvalid) begin
        rd_data <= exp_rdata;
      end
    end
  end

  // idle after last unit plus calculation latency
  logic syn_eval;

  always_ff @(posedge ref_clk) begin
    if (rst || init_reg) begin
      lat_reg     <= `CALC_LAT;
      idle_status <= 1'b0;
    end else if (absorbed_reg >= target_reg && !idle_status) begin
      if (lat_reg == 3'd0) begin
        idle_status <= 1'b1;
      end else begin
        lat_reg <= lat_reg - 3'd1;
      end
    end
  end

  assign syn_eval = (absorbed_reg >= target_reg) && !idle_status && (lat_reg == 3'd0) && !gen_l_reg;

  // syndrome evaluation
  logic [3:0] nz_count;

  always_comb begin
    nz_count = '0;
    for (int c = 0; c < 8; c++) begin
      if (4'(c) < nchunk_reg && 14'(par_reg >> (c * `CHUNK_BITS)) != 14'h0000) begin
        nz_count = nz_count + 4'd1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || init_reg) begin
      corr_required <= 1'b0;
      erased_page   <= 1'b0;
      poly_status   <= `STAT_NONE;
      error_count   <= '0;
      uncorrectable <= 1'b0;
    end else if (syn_eval) begin
      corr_required <= (nz_count != 4'd0);
      erased_page   <= all_ones_reg;
      error_count   <= nz_count;
      // an erased page gets no error summary in poly_status, so never uncorrectable either
      uncorrectable <= !all_ones_reg && (nz_count > (hamm_l_reg ? 4'd1 : strength_l_reg));
      if (nz_count == 4'd0 || all_ones_reg) begin
        poly_status <= `STAT_NONE;
      end else if (nz_count == 4'd1) begin
        poly_status <= `STAT_SINGLE;
      end else begin
        poly_status <= `STAT_MULTI;
      end
    end
  end

  // correction engine
  corr_state_e corr_state_reg;
  logic [3:0]  scan_idx_reg;
  logic        done_pulse_reg;
  logic        launch;
  logic [13:0] chunk;
  logic        lq_in_valid;
  logic        lq_in_ready;
  logic [10:0] lq_in_data;
  logic        lq_out_valid;
  logic        lq_out_ready;
  logic [10:0] lq_out_data;

  // start in bch, automatic single-error readout in hamming
  assign launch = hamm_l_reg ? (syn_eval && nz_count == 4'd1 && !all_ones_reg)
                             : (corr_start && !gen_l_reg);
  assign chunk  = 14'(par_reg >> (scan_idx_reg * `CHUNK_BITS));

  always_comb begin
    lq_in_valid = 1'b0;
    lq_in_data  = chunk[10:0];
    if (corr_state_reg == C_SCAN) begin
      lq_in_valid = (scan_idx_reg < nchunk_reg) && (chunk != 14'h0000);
    end else if (corr_state_reg == C_TERM) begin
      lq_in_valid = 1'b1;
      lq_in_data  = `TERM_INDEX;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      corr_state_reg <= C_IDLE;
      scan_idx_reg   <= '0;
      done_pulse_reg <= 1'b0;
    end else begin
      done_pulse_reg <= 1'b0;
      unique case (corr_state_reg)
        C_IDLE: begin
          scan_idx_reg <= '0;
          if (launch) begin
            corr_state_reg <= C_SCAN;
          end
        end
        C_SCAN: begin
          if (scan_idx_reg >= nchunk_reg) begin
            corr_state_reg <= C_TERM;
          end else if (!lq_in_valid || lq_in_ready) begin
            // stalls on a full location fifo
            scan_idx_reg <= scan_idx_reg + 4'd1;
          end
        end
        C_TERM: begin
          if (lq_in_ready) begin
            corr_state_reg <= C_DONE;
          end
        end
        C_DONE: begin
          done_pulse_reg <= 1'b1;
          corr_state_reg <= C_IDLE;
        end
      endcase
    end
  end

  // sticky done, a new done beats an init clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      locator_finished_status <= 1'b0;
    end else if (done_pulse_reg) begin
      locator_finished_status <= 1'b1;
    end else if (init_reg) begin
      locator_finished_status <= 1'b0;
    end
  end

  xfer_fifo #(
    .WIDTH (`LOC_WIDTH),
    .DEPTH (`LOC_FIFO_DEPTH)
  ) loc_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (lq_in_valid),
    .in_ready  (lq_in_ready),
    .in_data   (lq_in_data),
    .out_valid (lq_out_valid),
    .out_ready (lq_out_ready),
    .out_data  (lq_out_data)
  );

  assign lq_out_ready = !loc_valid || loc_read;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      loc_valid           <= 1'b0;
      error_location_port <= '0;
    end else if (lq_out_ready) begin
      loc_valid <= lq_out_valid;
      if (lq_out_valid) begin
        error_location_port <= lq_out_data;
      end
    end
  end
endmodule

// file: bench/nand_parity_ecc_engine_monitor.sv
// concurrent checks on the nand parity and ecc engine ports
`timescale 1ns/10ps
module nand_ecc_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        init_req,
  input wire logic        acc_valid,
  input wire logic        acc_ready,
  input wire logic        exp_valid,
  input wire logic        exp_ready,
  input wire logic        exp_write,
  input wire logic [2:0]  exp_cs,
  input wire logic [15:0] exp_wdata,
  input wire logic        exp_rvalid,
  input wire logic [15:0] exp_rdata,
  input wire logic        rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic        idle_status,
  input wire logic        corr_required,
  input wire logic        erased_page,
  input wire logic [2:0]  poly_status,
  input wire logic [3:0]  error_count,
  input wire logic        uncorrectable,
  input wire logic        locator_finished_status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_take_drops_ready: assert property (acc_valid && acc_ready |=> !acc_ready)
    else $error("acc_ready stayed high after a take");
  a_unit_held: assert property (exp_valid && !exp_ready |=> exp_valid && $stable({exp_write, exp_cs, exp_wdata}))
    else $error("expansion unit changed before completion");
  a_read_returned: assert property (exp_rvalid |=> rd_valid && rd_data == $past(exp_rdata))
    else $error("read unit not returned next cycle");
  a_read_caused: assert property (rd_valid |-> $past(exp_rvalid))
    else $error("rd_valid without a read unit");
  a_status_legal: assert property (poly_status inside {3'b000, 3'b001, 3'b100})
    else $error("illegal error summary code");
  a_single_count: assert property (idle_status && poly_status == 3'b001 |-> error_count == 4'd1 && corr_required)
    else $error("single error summary with wrong count");
  a_erased_clean: assert property (idle_status && erased_page |-> poly_status == 3'b000)
    else $error("erased page reported as error");
  a_uncorr_multi: assert property (idle_status && uncorrectable |-> poly_status == 3'b100 && error_count > 4'd1)
    else $error("uncorrectable without multiple errors");
  a_done_sticky: assert property (locator_finished_status && !init_req && !$past(init_req) |=> locator_finished_status)
    else $error("finished status dropped without init");
endmodule

bind nand_parity_ecc_engine nand_ecc_checker nand_ecc_checker_i (.ref_clk, .rst, .init_req, .acc_valid, .acc_ready,
  .exp_valid, .exp_ready, .exp_write, .exp_cs, .exp_wdata, .exp_rvalid, .exp_rdata, .rd_valid, .rd_data, .idle_status,
  .corr_required, .erased_page, .poly_status, .error_count, .uncorrectable, .locator_finished_status);

// file: bench/nand_flash_model.sv
// nand flash stand-in that plays recorded writes back on reads
`timescale 1ns/10ps
module nand_flash_model (
  input  wire logic        ref_clk,
  input  wire logic        exp_valid,
  output logic             exp_ready,
  input  wire logic        exp_write,
  input  wire logic [15:0] exp_wdata,
  output logic             exp_rvalid,
  output logic      [15:0] exp_rdata,
  input  wire logic        record,
  input  wire logic        erase,
  input  wire logic        fresh,
  input  wire logic        rewind,
  input  wire logic [4:0]  flip_at
);
  logic [7:0] mem [0:31];
  logic [4:0] wr_ptr = 0;
  logic [4:0] rd_ptr = 0;
  logic [1:0] wait_cnt = 0;
  logic [1:0] pace = 0;
  initial begin
    exp_ready = 0;
    exp_rvalid = 0;
    exp_rdata = 0;
  end
  always @(posedge ref_clk) begin
    exp_ready <= 1'b0;
    exp_rvalid <= 1'b0;
    // released data lines wander so stale data never looks valid
    exp_rdata <= ~exp_rdata;
    if (fresh) wr_ptr <= 0;
    if (rewind) rd_ptr <= 0;
    if (exp_valid && exp_ready) begin
      pace <= pace + 2'd1;
      wait_cnt <= 0;
      if (exp_write && record) begin
        mem[wr_ptr] <= exp_wdata[7:0];
        wr_ptr <= wr_ptr + 5'd1;
      end
    end else if (exp_valid) begin
      if (wait_cnt == pace) begin
        exp_ready <= 1'b1;
        if (!exp_write) begin
          exp_rvalid <= 1'b1;
          exp_rdata <= erase ? 16'h00ff : {8'h00, mem[rd_ptr] ^ {7'h00, rd_ptr == flip_at}};
          rd_ptr <= rd_ptr + 5'd1;
        end
      end else wait_cnt <= wait_cnt + 2'd1;
    end
  end
endmodule

// file: bench/nand_parity_ecc_engine_test.sv
// self-checking bench for the nand parity and ecc engine
`timescale 1ns/10ps
module nand_parity_ecc_engine_test;
  import ecc_engine_pkg::*;
  logic ref_clk, rst, prty_mode, hamm_mode, bus16, shift_en, parity_out_sel, init_req, corr_start;
  logic acc_valid, acc_ready, acc_write, rd_valid, exp_valid, exp_ready, exp_write, exp_rvalid;
  logic idle_status, corr_required, erased_page, uncorrectable, locator_finished_status, loc_read, loc_valid;
  logic record, erase, fresh, rewind, par_phase;
  logic [2:0] cs_select, acc_cs, exp_cs, poly_status;
  logic [3:0] ecc_strength, tag_in, error_count, corr_tag;
  logic [4:0] flip_at;
  logic [7:0] rnd;
  logic [10:0] error_location_port;
  logic [11:0] blk_size;
  logic [15:0] rd_data, exp_wdata, exp_rdata;
  logic [63:0] acc_wdata;
  xfer_size_e acc_size;
  logic [7:0] page [$];
  logic [18:0] expq [$];
  int error_cnt = 0;
  int n_checks = 0;
  int par_units;

  nand_parity_ecc_engine nand_parity_ecc_engine_i (.ref_clk, .rst, .prty_mode, .hamm_mode, .ecc_strength, .blk_size,
    .cs_select, .tag_in, .bus16, .shift_en, .parity_out_sel, .init_req, .corr_start, .acc_valid, .acc_ready, .acc_write,
    .acc_cs, .acc_size, .acc_wdata, .rd_valid, .rd_data, .exp_valid, .exp_ready, .exp_write, .exp_cs, .exp_wdata,
    .exp_rvalid, .exp_rdata, .idle_status, .corr_required, .erased_page, .poly_status, .error_count, .uncorrectable,
    .locator_finished_status, .corr_tag, .loc_read, .loc_valid, .error_location_port);
  nand_flash_model nand_flash_model_i (.ref_clk, .exp_valid, .exp_ready, .exp_write, .exp_wdata, .exp_rvalid,
    .exp_rdata, .record, .erase, .fresh, .rewind, .flip_at);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [19:0] got, input logic [19:0] want, input string what);
    n_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (exp_valid && exp_ready && exp_write) begin
      if (record) page.push_back(exp_wdata[7:0]);
      if (par_phase) begin
        par_units++;
        // parity goes to the nand cs
        chk(exp_cs, 3'd4, "parity unit cs");
      end else if (expq.size() > 0) begin
        chk({exp_cs, exp_wdata}, expq.pop_front(), "write unit");
      end
    end
  end

  task automatic acc(input logic wr, input logic [2:0] cs, input xfer_size_e sz, input logic [63:0] d);
    int n;
    n = (sz == SZ_WORD64) ? 8 : (sz == SZ_WORD32) ? 4 : 1;
    if (bus16 && n > 1) n = n / 2;
    if (wr && !par_phase) begin
      for (int i = 0; i < n; i++) expq.push_back(bus16 ? {cs, d[16*i +: 16]} : {cs, 8'h00, d[8*i +: 8]});
    end
    @(posedge ref_clk); #1;
    acc_valid = 1;
    acc_write = wr;
    acc_cs = cs;
    acc_size = sz;
    acc_wdata = d;
    do @(negedge ref_clk); while (acc_ready !== 1'b1);
    @(posedge ref_clk); #1;
    acc_valid = 0;
  endtask

  // lets every queued unit reach the nand before gates change
  task automatic drain;
    repeat (3) @(negedge ref_clk);
    for (int k = 0; k < 200 && exp_valid !== 1'b0; k++) @(negedge ref_clk);
    chk(exp_valid, 20'd0, "units drained");
    @(posedge ref_clk); #1;
  endtask

  task automatic init(input logic gen);
    @(posedge ref_clk); #1;
    prty_mode = gen;
    rnd = lfsr(rnd);
    tag_in = rnd[3:0];
    init_req = 1;
    fresh = gen;
    rewind = !gen;
    if (gen) page.delete();
    @(posedge ref_clk); #1;
    init_req = 0;
    fresh = 0;
    rewind = 0;
    // the internal init pulse acts one edge after the request is taken
    @(posedge ref_clk); #1;
  endtask

  task automatic wait_idle;
    for (int k = 0; k < 300 && idle_status !== 1'b1; k++) @(negedge ref_clk);
    @(posedge ref_clk); #1;
  endtask

  task automatic gen_job(input logic hm);
    logic [63:0] d;
    hamm_mode = hm;
    init(1);
    chk(idle_status, 0, "idle before data");
    acc(1, 3'd4, SZ_UNIT, 64'h90);
    drain;
    shift_en = 1;
    acc(1, 3'd2, SZ_UNIT, 64'h5a);
    drain;
    record = 1;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      d[8*i +: 8] = rnd;
    end
    acc(1, 3'd4, SZ_WORD64, d);
    drain;
    wait_idle;
    chk(idle_status, 1, "generation idle");
    parity_out_sel = 1;
    par_phase = 1;
    par_units = 0;
    acc(1, 3'd4, SZ_WORD32, 64'h0);
    drain;
    chk(20'(par_units), bus16 ? 20'd2 : 20'd4, "parity unit count");
    {parity_out_sel, par_phase, record, shift_en} = 4'h0;
  endtask

  task automatic rd_job(input int f, input logic er);
    logic [10:0] v;
    int n;
    flip_at = 5'(f);
    erase = er;
    init(0);
    shift_en = 1;
    for (int i = 0; i < 12; i++) begin
      acc(0, 3'd4, SZ_UNIT, 64'h0);
      for (int k = 0; k < 60 && rd_valid !== 1'b1; k++) @(negedge ref_clk);
      chk({rd_valid, rd_data}, {1'b1, (er ? 16'h00ff : {8'h00, page[i] ^ {7'h00, i == f}})}, "read data");
    end
    wait_idle;
    chk(idle_status, 1, "syndrome idle");
    chk(corr_tag, tag_in, "job tag");
    if (er) chk({erased_page, poly_status}, 4'b1000, "erased page");
    else if (f == 31) chk({corr_required, erased_page, poly_status}, 5'b00000, "clean block");
    else begin
      chk({corr_required, erased_page, error_count != 4'd0}, 3'b101, "error flags");
      chk(uncorrectable, error_count > (hamm_mode ? 4'd1 : 4'd2), "uncorrectable");
      if (!hamm_mode) begin
        corr_start = 1;
        @(posedge ref_clk); #1;
        corr_start = 0;
        v = 0;
        n = 0;
        for (int k = 0; k < 400 && v !== 11'h7fe; k++) begin
          @(posedge ref_clk); #1;
          if (loc_read) loc_read = 0;
          else if (loc_valid === 1'b1) begin
            v = error_location_port;
            n++;
            loc_read = 1;
          end
        end
        @(posedge ref_clk); #1;
        loc_read = 0;
        repeat (4) @(posedge ref_clk);
        chk(v, 11'h7fe, "list terminator");
        chk(20'(n), 20'(error_count) + 20'd1, "location count");
        chk(locator_finished_status, 1, "locator finished");
      end
    end
    shift_en = 0;
    erase = 0;
  endtask

  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    #400000;
    error_cnt++;
    end_sim;
  end

  initial begin
    {rst, prty_mode, hamm_mode, bus16, shift_en, parity_out_sel, init_req, corr_start} = 8'h80;
    {acc_valid, acc_write, loc_read, record, erase, fresh, rewind, par_phase} = 8'h00;
    {acc_cs, acc_wdata, tag_in} = 0;
    acc_size = SZ_UNIT;
    ecc_strength = 4'd2;
    blk_size = 12'd8;
    cs_select = 3'd4;
    flip_at = 5'd31;
    rnd = 8'd93;
    repeat (6) @(posedge ref_clk);
    #1;
    rst = 0;
    chk({acc_ready, exp_valid, rd_valid, idle_status, loc_valid, locator_finished_status}, 6'h20, "reset state");
    for (int m = 0; m < 2; m++) begin
      gen_job(m[0]);
      rd_job(31, 0);
      rd_job(3, 0);
      if (m == 0) rd_job(31, 1);
    end
    // halfword interface: splitting and parity emitted as halfwords
    bus16 = 1;
    gen_job(0);
    end_sim;
  end
endmodule
